// ---- tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, panel_fitted = 0, reg_wr = 0, reg_rd = 0, tick_d = 0;
   logic tick_en = 0, idx_req = 0, sel_req = 0;
   logic [3:0] mh_strap_n = 4'hF, fh_strap_n = 4'hE, mh_panel = 0, fh_panel = 0;
   logic [3:0] reg_addr = 0, sel_val = 0, m, f, s;
   logic [15:0] reg_wdata = 0, count_strap = 0, v;
   wire [15:0] reg_rdata;
   wire [3:0] sel_addr;
   wire sel_strobe, word_tick_pin, index_pin, mh_selected, fh_selected, unit_fault;
   wire sector_pulse, irq;
   int error_cnt = 0, n_tests = 0, cyc = 0, ticks = 0, seed = 32'h22d77019, cnt, q[$];
   int nsec = 0, ixc = 0;
   logic idx_d = 0;
   always #10 clk = ~clk;
   usc_host usc_host_i (.*);
   usc_unit_select #(.CW(16)) usc_unit_select_i (.*);
   // ----------------------------------------
   // bench model and timeout
   // ----------------------------------------
   always @(posedge clk)
   begin
      tick_d <= word_tick_pin;
      idx_d <= index_pin;
      if (index_pin && !idx_d)
      begin
         ixc = cyc;
         nsec = 0;
      end
      // a pulse launched before the synced index reaches the counter is not counted
      if (sector_pulse && cyc - ixc > 4) nsec++;
      if (word_tick_pin && !tick_d) ticks++;
      if (sector_pulse) q.push_back(ticks);
      if (++cyc == 40000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task complete_run;
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(1, v); chk("mask", 0, v);
      rd(2, v); chk("control", 0, v);
      rd(15, v); chk("unmapped", 0, v);
      // selection with a clash on the last pass; straps are inverted
      for (int i = 0; i < 8; i++)
      begin
         m = 4'($random(seed));
         f = (i == 7) ? m : 4'($random(seed));
         s = i[1] ? 4'($random(seed)) : (i[0] ? f : m);
         mh_strap_n <= ~m; fh_strap_n <= ~f;
         repeat (8) @(posedge clk);
         rd(3, v); chk("config", {7'h0, m == f, m, f}, v);
         @(posedge clk) {sel_val, sel_req} <= {s, 1'b1};
         @(posedge clk) sel_req <= 1'b0;
         repeat (12) @(posedge clk);
         chk("mh_sel", m == s && m != f, mh_selected);
         chk("fh_sel", f == s && m != f, fh_selected);
         chk("fault", m == f, unit_fault);
      end
      {panel_fitted, mh_panel, fh_panel} <= {1'b1, 4'h9, 4'h6};
      wr(2, 1);
      repeat (8) @(posedge clk);
      rd(3, v); chk("panel", 16'h096, v);
      wr(2, 0);
      {panel_fitted, mh_strap_n, fh_strap_n} <= {1'b0, 4'hE, 4'hD};
      wr(1, 1);
      // sector length from the host formula, period is count plus overhead
      for (int k = 0; k < 3; k++)
      begin
         cnt = 10078 / (200 + ($random(seed) & 255)) - 2;
         count_strap <= 16'(cnt);
         {tick_en, idx_req} <= 2'b11;
         repeat (4) @(posedge clk);
         idx_req <= 1'b0;
         q.delete();
         for (int w = 0; w < 3000 && q.size() < 3; w++) @(posedge clk);
         chk("sector_len", 16'(cnt + 2), 16'(q[2] - q[1]));
      end
      chk("irq", 1, irq);
      wr(1, 0);
      repeat (2) @(posedge clk);
      chk("irq_masked", 0, irq);
      tick_en <= 1'b0;
      repeat (12) @(posedge clk);
      rd(0, v); chk("status", 1, v[0]);
      rd(0, v); chk("status_clr", 0, v);
      rd(4, v); chk("sector_num", 16'(nsec), v);
      wr(1, 7);
      repeat (2) @(posedge clk);
      chk("irq_clr", 0, irq);
      complete_run();
   end
endmodule // tb_top

// ---- usc_chk.sv ----
module usc_chk(
   // clock and reset
   input wire logic        clk, rst_n,
   // pins and register port
   input wire logic [3:0]  mh_strap_n, fh_strap_n, sel_addr, reg_addr,
   input wire logic        panel_fitted, sel_strobe, word_tick_pin, reg_wr, reg_rd,
   input wire logic [15:0] reg_wdata, reg_rdata,
   // outputs
   input wire logic        mh_selected, fh_selected, unit_fault, sector_pulse, irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [12:0] pins, prev;
   logic [2:0]  stab;
   logic [3:0]  age;
   logic        st;
   assign pins = {mh_strap_n, fh_strap_n, sel_addr, panel_fitted};
   assign st = stab == 3'h7 && !panel_fitted;
   // pins cross two sync flops, so exact checks wait until inputs have settled
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         prev <= 13'h0;
         stab <= 3'h0;
         age  <= 4'hF;
      end
      else
      begin
         prev <= pins;
         stab <= (prev != pins) ? 3'h0 : stab + {2'h0, stab != 3'h7};
         age  <= word_tick_pin ? 4'h0 : age + {3'h0, age != 4'hF};
      end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_one_unit; !(mh_selected && fh_selected); endproperty
   a_one_unit: assert property (p_one_unit) else $error("both units selected");
   property p_config; reg_rd && reg_addr == 4'h3 && st |=>
      reg_rdata[8:0] == {mh_strap_n == fh_strap_n, ~mh_strap_n, ~fh_strap_n}; endproperty
   a_config: assert property (p_config) else $error("config read wrong");
   property p_sel_match; sel_strobe [*4] ##1 (sel_strobe && st && mh_strap_n != fh_strap_n)
      |-> mh_selected == (sel_addr == ~mh_strap_n) && fh_selected == (sel_addr == ~fh_strap_n);
   endproperty
   a_sel_match: assert property (p_sel_match) else $error("wrong unit answered");
   property p_fault; st |-> unit_fault == (mh_strap_n == fh_strap_n); endproperty
   a_fault: assert property (p_fault) else $error("clash flag wrong");
   property p_hold; !sel_strobe [*6] |-> $stable(mh_selected) && $stable(fh_selected); endproperty
   a_hold: assert property (p_hold) else $error("selection moved without strobe");
   property p_idle_rd; !$past(reg_rd) |-> reg_rdata == 16'h0; endproperty
   a_idle_rd: assert property (p_idle_rd) else $error("read data outside slot");
   property p_mask_off; reg_wr && reg_addr == 4'h1 && reg_wdata[2:0] == 3'h0 ##1 !reg_wr
      |=> !irq; endproperty
   a_mask_off: assert property (p_mask_off) else $error("masked irq high");
   property p_pulse; sector_pulse |-> age < 4'h7 ##1 !sector_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("sector pulse bad");
   c_pulse: cover property (sector_pulse);
   c_clash: cover property (unit_fault && sel_strobe);
   c_fh: cover property (fh_selected);
endmodule // usc_chk

bind usc_unit_select usc_chk usc_chk_i (.*);

// ---- usc_consts.vh ----
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH

// -----------------------------------------------------------------------------
// register offsets on the plain port
// -----------------------------------------------------------------------------
`define USC_REG_STATUS      4'h0
`define USC_REG_MASK        4'h1
`define USC_REG_CONTROL     4'h2
`define USC_REG_CONFIG      4'h3
`define USC_REG_SECTOR      4'h4

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define USC_EV_SECTOR       0
`define USC_EV_INDEX        1
`define USC_EV_FAULT        2
`define USC_CTL_PANEL       0

// -----------------------------------------------------------------------------
// reset values and timing counts
// -----------------------------------------------------------------------------
`define USC_MASK_RESET      3'h0
`define USC_CTL_RESET       1'h0
`define USC_OVH_WORDS       2'h2
`define USC_TRACK_WORDS     10078

`endif

// ---- usc_host.sv ----
module usc_host(
   // bench control
   input wire logic       clk, tick_en, idx_req, sel_req,
   input wire logic [3:0] sel_val,
   // pins toward the drive
   output logic [3:0]     sel_addr,
   output logic           sel_strobe, word_tick_pin, index_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph = 2'h0;
   logic [3:0] hold = 4'h0;
   initial {sel_addr, sel_strobe, word_tick_pin, index_pin} = 7'h0;
   // ticks two high two low; stand still when stopped
   always @(posedge clk)
   begin
      ph <= tick_en ? ph + 2'h1 : 2'h0;
      word_tick_pin <= tick_en && ph[1];
      index_pin <= idx_req;
      if (sel_req)
      begin
         sel_addr <= sel_val;
         sel_strobe <= 1'b1;
         hold <= 4'h8;
      end
      else if (hold != 4'h0)
         hold <= hold - 4'h1;
      else if (sel_strobe)
      begin
         // released lines must not show a stale address
         sel_addr <= ~sel_addr;
         sel_strobe <= 1'b0;
      end
   end
endmodule // usc_host

// ---- usc_sector_counter.v ----
`include "usc_consts.vh"

// word counter with overhead hold and sector boundary pulse
module usc_sector_counter #(
   parameter CW = 16
)(
   // clock and reset
   input  wire          clk,
   input  wire          rst_n,
   // word timing
   input  wire          word_tick,
   input  wire          index_mark,
   input  wire [CW-1:0] words_per_sector,
   // results
   output reg           sector_pulse,
   output reg  [7:0]    sector_number
);

   reg [CW-1:0] word_count;
   reg [1:0]    ovh_count;

   // -----------------------------------------------------------------------------
   // counting
   // -----------------------------------------------------------------------------
   // overhead count keeps the counter cleared for two word times
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word_count    <= {CW{1'b0}};
         ovh_count     <= 2'h0;
         sector_pulse  <= 1'b0;
         sector_number <= 8'h00;
      end
      else
      begin
         sector_pulse <= 1'b0;
         if (index_mark)
         begin
            word_count    <= {CW{1'b0}};
            ovh_count     <= `USC_OVH_WORDS;
            sector_number <= 8'h00;
         end
         else if (word_tick)
         begin
            if (ovh_count != 2'h0)
            begin
               ovh_count  <= ovh_count - 2'h1;
               word_count <= {CW{1'b0}};
            end
            else if (word_count + 1'b1 >= words_per_sector)
            begin
               sector_pulse  <= 1'b1;
               sector_number <= sector_number + 8'h01;
               word_count    <= {CW{1'b0}};
               ovh_count     <= `USC_OVH_WORDS;
            end
            else
               word_count <= word_count + 1'b1;
         end
      end
   end

endmodule // usc_sector_counter

// ---- usc_unit_select.v ----
`include "usc_consts.vh"

module usc_unit_select #(
   parameter CW = 16
)(
   // clock and reset
   input  wire          clk,
   input  wire          rst_n,
   // straps and panel (asynchronous pins)
   input  wire [3:0]    mh_strap_n,
   input  wire [3:0]    fh_strap_n,
   input  wire [3:0]    mh_panel,
   input  wire [3:0]    fh_panel,
   input  wire          panel_fitted,
   input  wire [CW-1:0] count_strap,
   // controller selection and drive timing (pins)
   input  wire [3:0]    sel_addr,
   input  wire          sel_strobe,
   input  wire          word_tick_pin,
   input  wire          index_pin,
   // register port
   input  wire [3:0]    reg_addr,
   input  wire [15:0]   reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output reg  [15:0]   reg_rdata,
   // outputs
   output reg           mh_selected,
   output reg           fh_selected,
   output reg           unit_fault,
   output reg           sector_pulse,
   output reg           irq
);

   // -----------------------------------------------------------------------------
   // reset release and pin synchronisers
   // -----------------------------------------------------------------------------
   reg [1:0] rst_sync;
   wire      rst_s_n = rst_sync[1];

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   localparam PW = 4 + 4 + 4 + 4 + 1 + CW + 4 + 1 + 1 + 1;
   reg [PW-1:0] pin_s1;
   reg [PW-1:0] pin_s2;

   // two-stage synchroniser; only the second stage is read
   always @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         pin_s1 <= {PW{1'b0}};
         pin_s2 <= {PW{1'b0}};
      end
      else
      begin
         pin_s1 <= {mh_strap_n, fh_strap_n, mh_panel, fh_panel, panel_fitted,
                    count_strap, sel_addr, sel_strobe, word_tick_pin, index_pin};
         pin_s2 <= pin_s1;
      end
   end

   wire [3:0]    s_mh_n   = pin_s2[PW-1 -: 4];
   wire [3:0]    s_fh_n   = pin_s2[PW-5 -: 4];
   wire [3:0]    s_mh_pn  = pin_s2[PW-9 -: 4];
   wire [3:0]    s_fh_pn  = pin_s2[PW-13 -: 4];
   wire          s_fitted = pin_s2[PW-17];
   wire [CW-1:0] s_count  = pin_s2[CW+6:7];
   wire [3:0]    s_sel    = pin_s2[6:3];
   wire          s_stb    = pin_s2[2];
   wire          s_tick   = pin_s2[1];
   wire          s_index  = pin_s2[0];

   // -----------------------------------------------------------------------------
   // address resolution
   // -----------------------------------------------------------------------------
   reg        use_panel;
   reg [2:0]  irq_mask;
   reg [2:0]  irq_status;
   reg        tick_d;
   reg        index_d;

   // active-low straps: a grounded pin is a one, so invert
   function [3:0] strap_addr;
      input [3:0] pins_n;
      begin
         strap_addr = ~pins_n;
      end
   endfunction

   // software may disable the panel even when fitted
   wire       panel_on = s_fitted & use_panel;
   wire [3:0] mh_addr  = panel_on ? s_mh_pn : strap_addr(s_mh_n);
   wire [3:0] fh_addr  = panel_on ? s_fh_pn : strap_addr(s_fh_n);
   wire       clash    = (mh_addr == fh_addr);
   wire       tick_rise  = s_tick & ~tick_d;
   wire       index_rise = s_index & ~index_d;
   wire       sec_evt;
   wire [7:0] sec_num;

   // -----------------------------------------------------------------------------
   // sector counter
   // -----------------------------------------------------------------------------
   usc_sector_counter #(
      .CW (CW)
   ) u_counter (
      .clk              (clk),
      .rst_n            (rst_s_n),
      .word_tick        (tick_rise),
      .index_mark       (index_rise),
      .words_per_sector (s_count),
      .sector_pulse     (sec_evt),
      .sector_number    (sec_num)
   );

   // -----------------------------------------------------------------------------
   // selection, fault and output flops
   // -----------------------------------------------------------------------------
   // a clashing pair answers nothing; selection is refused while in fault
   always @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         mh_selected  <= 1'b0;
         fh_selected  <= 1'b0;
         unit_fault   <= 1'b0;
         sector_pulse <= 1'b0;
         tick_d       <= 1'b0;
         index_d      <= 1'b0;
      end
      else
      begin
         tick_d       <= s_tick;
         index_d      <= s_index;
         unit_fault   <= clash;
         sector_pulse <= sec_evt;
         if (s_stb)
         begin
            mh_selected <= ~clash & (s_sel == mh_addr);
            fh_selected <= ~clash & (s_sel == fh_addr);
         end
      end
   end

   // -----------------------------------------------------------------------------
   // register port and interrupt
   // -----------------------------------------------------------------------------
   // status sets win over the clear-on-read in the same cycle
   wire [2:0] ev_set  = {clash & ~unit_fault, index_rise, sec_evt};
   wire       st_read = reg_rd & (reg_addr == `USC_REG_STATUS);

   always @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         irq_status <= 3'h0;
         irq_mask   <= `USC_MASK_RESET;
         use_panel  <= `USC_CTL_RESET;
         reg_rdata  <= 16'h0000;
         irq        <= 1'b0;
      end
      else
      begin
         irq_status <= (st_read ? 3'h0 : irq_status) | ev_set;
         irq        <= |(irq_status & irq_mask);
         if (reg_wr && reg_addr == `USC_REG_MASK)
            irq_mask <= reg_wdata[2:0];
         if (reg_wr && reg_addr == `USC_REG_CONTROL)
            use_panel <= reg_wdata[`USC_CTL_PANEL];
         reg_rdata <= 16'h0000;
         if (reg_rd)
         begin
            case (reg_addr)
               `USC_REG_STATUS:  reg_rdata <= {13'h0000, irq_status};
               `USC_REG_MASK:    reg_rdata <= {13'h0000, irq_mask};
               `USC_REG_CONTROL: reg_rdata <= {15'h0000, use_panel};
               `USC_REG_CONFIG:  reg_rdata <= {7'h00, clash, mh_addr, fh_addr};
               `USC_REG_SECTOR:  reg_rdata <= {8'h00, sec_num};
               default:          reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

endmodule // usc_unit_select
